// ===== sdinit_defines.svh
/*
 * shared constants for the sdram init / mode setup pair: opcode field
 * positions, decode codes and power-on timing counts.
 * assumes a single 100 MHz system clock shared by both ends.
 */
`ifndef SDINIT_DEFINES_SVH
`define SDINIT_DEFINES_SVH

// clock period in ns
`define SDINIT_CLK_NS          10
// power-on hold time in us, and its cycle count (least time, rounded up)
`define SDINIT_HOLD_US         100
`define SDINIT_HOLD_CYC        ((`SDINIT_HOLD_US * 1000 + 10 - 1) / 10)
// least gap after a mode load, in cycles
`define SDINIT_MRS_GAP         2
// least auto-refresh count during init
`define SDINIT_MIN_REFRESH     2

// opcode field positions
`define SDINIT_BL_LSB          0
`define SDINIT_BL_MSB          2
`define SDINIT_BT_BIT          3
`define SDINIT_LT_LSB          4
`define SDINIT_LT_MSB          6
`define SDINIT_OPT_LSB         7
`define SDINIT_OPT_MSB         11

// burst count codes
`define SDINIT_BL_CODE_1       3'h0
`define SDINIT_BL_CODE_2       3'h1
`define SDINIT_BL_CODE_4       3'h2
`define SDINIT_BL_CODE_8       3'h3
`define SDINIT_BL_CODE_PAGE    3'h7
// read latency codes
`define SDINIT_LT_CODE_2       3'h2
`define SDINIT_LT_CODE_3       3'h3
// mode option codes (bits 11..7)
`define SDINIT_OPT_BURST_WR    5'h00
`define SDINIT_OPT_SINGLE_WR   5'h04
// full page burst length
`define SDINIT_PAGE_LEN        9'h100
// reset value of the stored opcode
`define SDINIT_MODE_RST        12'h000

`endif

// ===== sdinit_pkg.sv
/*
 * types shared by the controller end and the device end.
 * assumes sdinit_defines.svh is compiled alongside.
 */
package sdinit_pkg;

	// decoded pin command
	typedef enum logic [2:0] {
		SDINIT_CMD_NOP,
		SDINIT_CMD_ACT,
		SDINIT_CMD_READ,
		SDINIT_CMD_WRITE,
		SDINIT_CMD_PRE,
		SDINIT_CMD_REF,
		SDINIT_CMD_MRS
	} sdinit_cmd_t;

endpackage : sdinit_pkg

// ===== sdinit_if.sv
/*
 * pin bundle between the memory controller and the sdram device.
 * assumes both ends share one clock; dq is split into in/out/enable.
 */
`timescale 1ns/10ps
interface sdinit_if;
	logic        cke;       // clock enable
	logic        cs_n;      // chip select, active low
	logic        ras_n;     // row strobe, active low
	logic        cas_n;     // column strobe, active low
	logic        we_n;      // write enable, active low
	logic [11:0] addr;      // address / opcode
	logic [1:0]  dqm;       // byte masks
	logic [15:0] dq_wr;     // data from controller
	logic        dq_wr_oe_n;// controller drives dq when low
	logic [15:0] dq_rd;     // data from device
	logic        dq_rd_oe_n;// device drives dq when low

	modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, addr, dqm, dq_wr, dq_wr_oe_n,
		input dq_rd, dq_rd_oe_n);
	modport dev (input cke, cs_n, ras_n, cas_n, we_n, addr, dqm, dq_wr, dq_wr_oe_n,
		output dq_rd, dq_rd_oe_n);
endinterface : sdinit_if

// ===== sdinit_dev.sv
/*
 * device end: mode register capture and decode, plus a small burst
 * engine (address sequencing, read latency, single/burst write).
 * assumes controller pins are synchronous to i_core_clk (same clock),
 * so no synchronisers; a tiny array stands in for the cell array.
 */
`timescale 1ns/10ps
`include "sdinit_defines.svh"
module sdinit_dev #(
	parameter int COL_W = 8    // column address width
) (
	input  wire logic i_core_clk,
	input  wire logic i_rstn,
	sdinit_if.dev     pins,
	output logic [11:0] o_mode,         // stored opcode
	output logic        o_mode_loaded,  // a mode load has been seen
	output logic        o_mode_illegal, // stored opcode holds reserved codes
	output logic        o_order_err     // mode load seen with a bank open
);

	////////////////////////////////////////////////////////////////////////
	// command decode
	sdinit_pkg::sdinit_cmd_t cmd;    // decoded command this cycle

	// cke low or deselect read as nop
	always_comb begin
		cmd = sdinit_pkg::SDINIT_CMD_NOP;
		if (pins.cke && !pins.cs_n) begin
			unique case ({pins.ras_n, pins.cas_n, pins.we_n})
				3'b011:  cmd = sdinit_pkg::SDINIT_CMD_ACT;
				3'b101:  cmd = sdinit_pkg::SDINIT_CMD_READ;
				3'b100:  cmd = sdinit_pkg::SDINIT_CMD_WRITE;
				3'b010:  cmd = sdinit_pkg::SDINIT_CMD_PRE;
				3'b001:  cmd = sdinit_pkg::SDINIT_CMD_REF;
				3'b000:  cmd = sdinit_pkg::SDINIT_CMD_MRS;
				default: cmd = sdinit_pkg::SDINIT_CMD_NOP;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode register
	logic [11:0] mode_ff;     // captured opcode
	logic        loaded_ff;   // mode loaded flag

	// capture all twelve pins whatever refresh order was used
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			mode_ff   <= `SDINIT_MODE_RST;
			loaded_ff <= 1'b0;
		end else if (cmd == sdinit_pkg::SDINIT_CMD_MRS) begin
			mode_ff   <= pins.addr;
			loaded_ff <= 1'b1;
		end
	end

	// field split
	logic [2:0] burst_count_field;  // length code
	logic       burst_order_field;  // order bit
	logic [2:0] read_latency_field; // latency code
	logic [4:0] mode_opt;           // option bits
	assign burst_count_field  = mode_ff[`SDINIT_BL_MSB:`SDINIT_BL_LSB];
	assign burst_order_field  = mode_ff[`SDINIT_BT_BIT];
	assign read_latency_field = mode_ff[`SDINIT_LT_MSB:`SDINIT_LT_LSB];
	assign mode_opt           = mode_ff[`SDINIT_OPT_MSB:`SDINIT_OPT_LSB];

	////////////////////////////////////////////////////////////////////////
	// decode of fields
	logic [8:0] burst_len;   // transfers per burst
	logic       len_bad;     // reserved length code
	logic [1:0] rd_lat;      // latency in cycles
	logic       lat_bad;     // reserved latency code
	logic       single_wr;   // single write mode
	logic       opt_bad;     // reserved option bits

	// length: page only in sequential order
	always_comb begin
		len_bad = 1'b0;
		unique case (burst_count_field)
			`SDINIT_BL_CODE_1:    burst_len = 9'h001;
			`SDINIT_BL_CODE_2:    burst_len = 9'h002;
			`SDINIT_BL_CODE_4:    burst_len = 9'h004;
			`SDINIT_BL_CODE_8:    burst_len = 9'h008;
			`SDINIT_BL_CODE_PAGE: begin
				burst_len = `SDINIT_PAGE_LEN;
				len_bad   = burst_order_field;
			end
			default: begin
				burst_len = 9'h001;
				len_bad   = 1'b1;
			end
		endcase
	end

	// latency: two and three only, reserved falls back to three
	always_comb begin
		lat_bad = 1'b0;
		unique case (read_latency_field)
			`SDINIT_LT_CODE_2: rd_lat = 2'd2;
			`SDINIT_LT_CODE_3: rd_lat = 2'd3;
			default: begin
				rd_lat  = 2'd3;
				lat_bad = 1'b1;
			end
		endcase
	end

	assign single_wr = (mode_opt == `SDINIT_OPT_SINGLE_WR);
	assign opt_bad   = (mode_opt != `SDINIT_OPT_BURST_WR) && !single_wr;

	// reserved codes flagged rather than trusted
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) o_mode_illegal <= 1'b0;
		else         o_mode_illegal <= loaded_ff && (len_bad || lat_bad || opt_bad);
	end

	////////////////////////////////////////////////////////////////////////
	// bank tracking (open row)
	logic [1:0] open_ff;   // bank has an open row

	// precharge with a10 closes both, else the a11 bank
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) open_ff <= 2'b00;
		else if (cmd == sdinit_pkg::SDINIT_CMD_ACT) open_ff[pins.addr[11]] <= 1'b1;
		else if (cmd == sdinit_pkg::SDINIT_CMD_PRE) begin
			if (pins.addr[10]) open_ff <= 2'b00;
			else               open_ff[pins.addr[11]] <= 1'b0;
		end
	end

	// sticky: a mode load with a bank open is a controller fault
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) o_order_err <= 1'b0;
		else if (cmd == sdinit_pkg::SDINIT_CMD_MRS && open_ff != 2'b00)
			o_order_err <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// burst engine
	logic [15:0]      mem [0:(1<<(COL_W+1))-1]; // tiny cell array, bank+column
	logic             rd_ff, wr_ff;             // burst in progress
	logic             bank_ff;                  // burst bank
	logic [COL_W-1:0] start_ff;                 // start column
	logic [8:0]       beat_ff;                  // beat index
	logic [8:0]       len_ff;                   // beats in this burst
	logic [COL_W-1:0] cur_col;                  // column for this beat
	logic [COL_W-1:0] wr_col;                   // column for a new write
	logic [8:0]       mask;                     // wrap mask

	// wrap inside the burst boundary; interleave xors the beat in
	assign mask = len_ff - 9'd1;
	always_comb begin
		if (burst_order_field)
			cur_col = (start_ff & ~mask[COL_W-1:0]) |
				((start_ff ^ beat_ff[COL_W-1:0]) & mask[COL_W-1:0]);
		else
			cur_col = (start_ff & ~mask[COL_W-1:0]) |
				((start_ff + beat_ff[COL_W-1:0]) & mask[COL_W-1:0]);
	end
	assign wr_col = pins.addr[COL_W-1:0];

	// a new read or write cuts the running burst
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rd_ff    <= 1'b0;
			wr_ff    <= 1'b0;
			bank_ff  <= 1'b0;
			start_ff <= '0;
			beat_ff  <= 9'h000;
			len_ff   <= 9'h001;
		end else if (cmd == sdinit_pkg::SDINIT_CMD_READ ||
			cmd == sdinit_pkg::SDINIT_CMD_WRITE) begin
			rd_ff    <= (cmd == sdinit_pkg::SDINIT_CMD_READ);
			bank_ff  <= pins.addr[11];
			start_ff <= wr_col;
			// write beat 0 is taken now, so a write resumes at beat 1
			beat_ff  <= (cmd == sdinit_pkg::SDINIT_CMD_READ) ? 9'h000 : 9'h001;
			len_ff   <= burst_len;
			wr_ff    <= (cmd == sdinit_pkg::SDINIT_CMD_WRITE) && !single_wr &&
				(burst_len != 9'h001);
		end else if (rd_ff || wr_ff) begin
			// full page never ends by itself
			if (beat_ff == len_ff - 9'd1 && len_ff != `SDINIT_PAGE_LEN) begin
				rd_ff <= 1'b0;
				wr_ff <= 1'b0;
			end
			beat_ff <= (beat_ff == len_ff - 9'd1) ? 9'h000 : beat_ff + 9'd1;
		end
	end

	// writes: beat 0 in the command cycle, then follow-on beats
	always_ff @(posedge i_core_clk) begin
		if (cmd == sdinit_pkg::SDINIT_CMD_WRITE && !pins.dq_wr_oe_n)
			mem[{pins.addr[11], wr_col}] <= pins.dq_wr;
		else if (wr_ff && !pins.dq_wr_oe_n)
			mem[{bank_ff, cur_col}] <= pins.dq_wr;
	end

	// read pipe: one extra stage, used only for latency three
	logic [15:0] rpipe_d;  // beat delayed by one cycle
	logic        rpipe_v;  // valid of the delayed beat
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rpipe_v <= 1'b0;
			rpipe_d <= 16'h0000;
		end else begin
			rpipe_v <= rd_ff;
			rpipe_d <= mem[{bank_ff, cur_col}];
		end
	end

	// beat 0 is live the cycle after the command, and the pin register
	// adds one more, so latency two drives the live beat straight out
	logic lat3;   // latency three takes the delayed beat
	assign lat3 = (rd_lat == 2'd3);
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pins.dq_rd      <= 16'h0000;
			pins.dq_rd_oe_n <= 1'b1;
		end else begin
			pins.dq_rd      <= lat3 ? rpipe_d : mem[{bank_ff, cur_col}];
			pins.dq_rd_oe_n <= lat3 ? !rpipe_v : !rd_ff;
		end
	end

	assign o_mode        = mode_ff;
	assign o_mode_loaded = loaded_ff;

endmodule : sdinit_dev

// ===== sdinit_ctrl.sv
/*
 * controller end: power-on hold, precharge-all, refreshes and mode
 * load, then hands the pins to simple user command strobes.
 * assumes the device shares i_core_clk; user inputs are same-clock.
 */
`timescale 1ns/10ps
`include "sdinit_defines.svh"
module sdinit_ctrl #(
	parameter int HOLD_CYC   = `SDINIT_HOLD_CYC,   // power-on hold cycles
	parameter int N_REFRESH  = `SDINIT_MIN_REFRESH, // init refresh count
	parameter bit MODE_FIRST = 1'b0                // load mode before refreshes
) (
	input  wire logic        i_core_clk,
	input  wire logic        i_rstn,
	sdinit_if.ctrl           pins,
	input  wire logic [11:0] i_mode,      // opcode to load at init
	input  wire logic        i_cmd_vld,   // user command request
	input  wire logic [2:0]  i_cmd,       // sdinit_cmd_t code
	input  wire logic [11:0] i_addr,      // user address
	input  wire logic [15:0] i_wdata,     // user write data
	input  wire logic        i_wdata_vld, // drive write data this cycle
	output logic             o_cmd_rdy,   // request taken this cycle
	output logic             o_init_done, // init finished
	output logic [15:0]      o_rdata,     // read data
	output logic             o_rdata_vld  // read data valid
);

	typedef enum logic [2:0] {HOLD, PALL, REFR, MLOAD, GAP, RUN} sdinit_st_t;
	sdinit_st_t st_ff;                 // init state
	logic [31:0] cnt_ff;               // hold / gap counter
	logic [7:0]  ref_ff;               // refreshes issued
	logic        mode_done_ff;         // mode already loaded

	////////////////////////////////////////////////////////////////////////
	// init sequencer
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_ff        <= HOLD;
			cnt_ff       <= 32'h0000_0000;
			ref_ff       <= 8'h00;
			mode_done_ff <= 1'b0;
		end else begin
			unique case (st_ff)
				HOLD: begin
					// hold cke and masks high before any command
					if (cnt_ff == 32'(HOLD_CYC - 1)) st_ff <= PALL;
					else cnt_ff <= cnt_ff + 32'd1;
				end
				PALL: st_ff <= MODE_FIRST ? MLOAD : REFR;
				REFR: begin
					ref_ff <= ref_ff + 8'd1;
					if (ref_ff == 8'(N_REFRESH - 1))
						st_ff <= mode_done_ff ? RUN : MLOAD;
				end
				MLOAD: begin
					mode_done_ff <= 1'b1;
					cnt_ff       <= 32'h0000_0000;
					st_ff        <= GAP;
				end
				GAP: begin
					// two quiet cycles after the mode load
					if (cnt_ff == 32'(`SDINIT_MRS_GAP - 1))
						st_ff <= (ref_ff == 8'(N_REFRESH)) ? RUN : REFR;
					else cnt_ff <= cnt_ff + 32'd1;
				end
				RUN: st_ff <= RUN;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pin drive
	logic [3:0] nxt_cmd;   // cs,ras,cas,we
	logic [11:0] nxt_addr; // address to drive
	always_comb begin
		nxt_cmd   = 4'b0111;
		nxt_addr  = 12'h000;
		o_cmd_rdy = 1'b0;
		unique case (st_ff)
			PALL: begin
				nxt_cmd  = 4'b0010;
				nxt_addr = 12'h400; // a10 high closes both banks
			end
			REFR:  nxt_cmd = 4'b0001;
			MLOAD: begin
				nxt_cmd  = 4'b0000;
				nxt_addr = i_mode;
			end
			RUN: begin
				o_cmd_rdy = i_cmd_vld;
				nxt_addr  = i_addr;
				if (i_cmd_vld) begin
					unique case (sdinit_pkg::sdinit_cmd_t'(i_cmd))
						sdinit_pkg::SDINIT_CMD_ACT:   nxt_cmd = 4'b0011;
						sdinit_pkg::SDINIT_CMD_READ:  nxt_cmd = 4'b0101;
						sdinit_pkg::SDINIT_CMD_WRITE: nxt_cmd = 4'b0100;
						sdinit_pkg::SDINIT_CMD_PRE:   nxt_cmd = 4'b0010;
						sdinit_pkg::SDINIT_CMD_REF:   nxt_cmd = 4'b0001;
						sdinit_pkg::SDINIT_CMD_MRS:   nxt_cmd = 4'b0000;
						default:                      nxt_cmd = 4'b0111;
					endcase
				end
			end
			default: nxt_cmd = 4'b0111;
		endcase
	end

	// registered pin outputs; cke and masks high from reset
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pins.cke        <= 1'b1;
			pins.dqm        <= 2'b11;
			{pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= 4'b1111;
			pins.addr       <= 12'h000;
			pins.dq_wr      <= 16'h0000;
			pins.dq_wr_oe_n <= 1'b1;
		end else begin
			pins.cke        <= 1'b1;
			pins.dqm        <= (st_ff == RUN) ? 2'b00 : 2'b11;
			{pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= nxt_cmd;
			pins.addr       <= nxt_addr;
			pins.dq_wr      <= i_wdata;
			pins.dq_wr_oe_n <= !(st_ff == RUN && i_wdata_vld);
		end
	end

	// read return
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata     <= 16'h0000;
			o_rdata_vld <= 1'b0;
			o_init_done <= 1'b0;
		end else begin
			o_rdata     <= pins.dq_rd;
			o_rdata_vld <= !pins.dq_rd_oe_n;
			o_init_done <= (st_ff == RUN);
		end
	end

endmodule : sdinit_ctrl

// ===== sdinit_properties.sv
/*
 * concurrent checks on the pins between controller and device.
 * assumes one clock, async active-low reset, registered pin outputs.
 */
`timescale 1ns/10ps
module sdinit_properties #(
	parameter int HOLD_CYC = 20 // power-on hold cycles
) (
	input wire logic        i_core_clk,
	input wire logic        i_rstn,
	input wire logic        cke,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic [11:0] addr,
	input wire logic [1:0]  dqm,
	input wire logic        dq_wr_oe_n,
	input wire logic        dq_rd_oe_n
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	////////////////////////////////////////////////////////////////
	logic        is_cmd, is_pre, is_ref, is_mrs, is_act, is_rd, is_wr;
	logic [15:0] cyc_ff;   // cycles since release, saturating
	logic        first_ff; // no command seen yet
	logic [1:0]  refs_ff;  // refreshes seen, stops at 3
	logic        mrs_ff;   // a mode load seen
	logic [1:0]  open_ff;  // one flag per bank
	logic [2:0]  lat_ff;   // latency code last loaded
	assign is_cmd = !cs_n && !(ras_n && cas_n && we_n);
	assign is_pre = is_cmd && !ras_n && cas_n && !we_n;
	assign is_ref = is_cmd && !ras_n && !cas_n && we_n;
	assign is_mrs = is_cmd && !ras_n && !cas_n && !we_n;
	assign is_act = is_cmd && !ras_n && cas_n && we_n;
	assign is_rd  = is_cmd && ras_n && !cas_n && we_n;
	assign is_wr  = is_cmd && ras_n && !cas_n && !we_n;
	////////////////////////////////////////////////////////////////
	// saturates so a long run never wraps back into the hold window
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) cyc_ff <= 16'h0000;
		else if (cyc_ff != 16'hffff) cyc_ff <= cyc_ff + 16'h0001;
	end
	// init progress
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			first_ff <= 1'b1;
			refs_ff <= 2'h0;
			mrs_ff <= 1'b0;
		end else begin
			if (is_cmd) first_ff <= 1'b0;
			if (is_ref && refs_ff != 2'h3) refs_ff <= refs_ff + 2'h1;
			if (is_mrs) mrs_ff <= 1'b1;
		end
	end
	// open banks and loaded latency
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			open_ff <= 2'h0;
			lat_ff <= 3'h0;
		end else begin
			if (is_act) open_ff[addr[11]] <= 1'b1;
			if (is_pre && addr[10]) open_ff <= 2'h0;
			else if (is_pre) open_ff[addr[11]] <= 1'b0;
			if (is_mrs) lat_ff <= addr[6:4];
		end
	end
	////////////////////////////////////////////////////////////////
	property p_hold;
		cyc_ff < HOLD_CYC |-> cke && dqm == 2'h3 && !is_cmd;
	endproperty
	a_hold: assert property (p_hold) else $error("pins not quiet in hold");
	property p_first;
		first_ff && is_cmd |-> is_pre && addr[10];
	endproperty
	a_first: assert property (p_first) else $error("first command not pall");
	property p_init_order;
		is_act || is_rd || is_wr |-> mrs_ff && refs_ff >= 2'h2;
	endproperty
	a_init_order: assert property (p_init_order) else $error("init incomplete");
	property p_mrs_order;
		is_mrs && !mrs_ff |-> refs_ff != 2'h1;
	endproperty
	a_mrs_order: assert property (p_mrs_order) else $error("mode load order");
	property p_mrs_idle;
		is_mrs |-> open_ff == 2'h0;
	endproperty
	a_mrs_idle: assert property (p_mrs_idle) else $error("mode load with bank open");
	property p_mrs_gap;
		is_mrs |=> !is_cmd [*2];
	endproperty
	a_mrs_gap: assert property (p_mrs_gap) else $error("command too soon");
	property p_wr_data;
		is_wr |-> !dq_wr_oe_n;
	endproperty
	a_wr_data: assert property (p_wr_data) else $error("no data with write");
	property p_lat2;
		is_rd && lat_ff == 3'h2 |-> ##2 !dq_rd_oe_n;
	endproperty
	a_lat2: assert property (p_lat2) else $error("latency two missed");
	property p_lat3;
		is_rd && lat_ff == 3'h3 |-> ##3 !dq_rd_oe_n;
	endproperty
	a_lat3: assert property (p_lat3) else $error("latency three missed");
	c_mrs: cover property (is_mrs ##1 !is_cmd ##1 !is_cmd);
	c_rd3: cover property (is_rd && lat_ff == 3'h3);
	c_wr: cover property (is_wr);
endmodule : sdinit_properties

// ===== tb.sv
/*
 * self-checking bench: controller and device joined by one bundle,
 * plus a second pair that loads the mode before its refreshes.
 * assumes 100 MHz clock, reset held 6 cycles, shortened hold count.
 */
`timescale 1ns/10ps
module tb;
	localparam int HOLD  = 20; // shortened so the run stays short
	localparam int N_REF = 2;  // init refreshes
	localparam logic [15:0] DA [4] = '{16'h5a00, 16'h5a01, 16'h5a02, 16'h5a03};
	localparam logic [11:0] RSV [7] = '{12'h024, 12'h025, 12'h026, 12'h02f,
		12'h002, 12'h0a2, 12'h422};
	logic        i_core_clk = 1'b0; // system clock
	logic        i_rstn;            // async reset
	logic [11:0] i_mode;            // init opcode
	logic        i_cmd_vld;         // user request
	logic [2:0]  i_cmd;             // user command
	logic [11:0] i_addr;            // user address
	logic [15:0] i_wdata;           // write beat
	logic        i_wdata_vld;       // write beat valid
	logic        o_cmd_rdy, o_init_done, o_rdata_vld, done2;
	logic [15:0] o_rdata;
	logic [11:0] dmode, dmode2;
	logic        dloaded, dloaded2, dill, derr;
	int          err_count, total_checks, first_cyc, refs;
	bit          seen;
	sdinit_if bus_a ();
	sdinit_if bus_b ();
	////////////////////////////////////////////////////////////////
	sdinit_ctrl #(.HOLD_CYC(HOLD), .N_REFRESH(N_REF), .MODE_FIRST(1'b0)) sdinit_ctrl_inst (
		.i_core_clk(i_core_clk), .i_rstn(i_rstn), .pins(bus_a.ctrl), .i_mode(i_mode),
		.i_cmd_vld(i_cmd_vld), .i_cmd(i_cmd), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wdata_vld(i_wdata_vld), .o_cmd_rdy(o_cmd_rdy), .o_init_done(o_init_done),
		.o_rdata(o_rdata), .o_rdata_vld(o_rdata_vld));
	sdinit_dev sdinit_dev_inst (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .pins(bus_a.dev),
		.o_mode(dmode), .o_mode_loaded(dloaded), .o_mode_illegal(dill), .o_order_err(derr));
	// second pair only shows that either init order is accepted
	sdinit_ctrl #(.HOLD_CYC(HOLD), .N_REFRESH(N_REF), .MODE_FIRST(1'b1)) sdinit_ctrl_inst_b (
		.i_core_clk(i_core_clk), .i_rstn(i_rstn), .pins(bus_b.ctrl), .i_mode(i_mode),
		.i_cmd_vld(1'b0), .i_cmd(3'h0), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wdata_vld(1'b0), .o_cmd_rdy(), .o_init_done(done2), .o_rdata(), .o_rdata_vld());
	sdinit_dev sdinit_dev_inst_b (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .pins(bus_b.dev),
		.o_mode(dmode2), .o_mode_loaded(dloaded2), .o_mode_illegal(), .o_order_err());
	sdinit_properties #(.HOLD_CYC(HOLD)) sdinit_properties_inst (.i_core_clk(i_core_clk),
		.i_rstn(i_rstn), .cke(bus_a.cke), .cs_n(bus_a.cs_n), .ras_n(bus_a.ras_n),
		.cas_n(bus_a.cas_n), .we_n(bus_a.we_n), .addr(bus_a.addr), .dqm(bus_a.dqm),
		.dq_wr_oe_n(bus_a.dq_wr_oe_n), .dq_rd_oe_n(bus_a.dq_rd_oe_n));
	always #5 i_core_clk = ~i_core_clk;
	////////////////////////////////////////////////////////////////
	// first command time and refreshes before the mode load
	always @(posedge i_core_clk) begin
		if (!i_rstn) begin
			first_cyc = 0;
			seen = 1'b0;
			refs = 0;
		end else begin
			if (!bus_a.cs_n && !(bus_a.ras_n && bus_a.cas_n && bus_a.we_n)) seen = 1'b1;
			else if (!seen) first_cyc++;
			if (!bus_a.cs_n && !bus_a.ras_n && !bus_a.cas_n && bus_a.we_n && !dloaded) refs++;
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge i_core_clk);
			#1;
		end
	endtask : idle
	// request is taken at the next edge since ready follows valid in run
	task automatic issue(input sdinit_pkg::sdinit_cmd_t c, input logic [11:0] a);
		i_cmd_vld = 1'b1;
		i_cmd = c;
		i_addr = a;
		@(posedge i_core_clk);
		chk(16'(o_cmd_rdy), 16'h0001, "request taken");
		#1;
		i_cmd_vld = 1'b0;
	endtask : issue
	task automatic opn();
		issue(sdinit_pkg::SDINIT_CMD_ACT, 12'h000);
		idle(1);
	endtask : opn
	task automatic load_mode_command(input logic [11:0] m);
		issue(sdinit_pkg::SDINIT_CMD_PRE, 12'h400);
		idle(1); // valid must not drop and rise in one time step
		issue(sdinit_pkg::SDINIT_CMD_MRS, m);
		idle(2);
		chk(16'(dmode), 16'(m), "stored opcode");
	endtask : load_mode_command
	task automatic wr(input logic [11:0] a, input logic [15:0] d [4]);
		i_wdata = d[0];
		i_wdata_vld = 1'b1;
		issue(sdinit_pkg::SDINIT_CMD_WRITE, a);
		for (int k = 1; k < 4; k++) begin
			i_wdata = d[k];
			idle(1);
		end
		i_wdata_vld = 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input int n, input int lat,
		input logic [15:0] e [4], input bit cmp);
		int w;
		w = 0;
		issue(sdinit_pkg::SDINIT_CMD_READ, a);
		while (o_rdata_vld !== 1'b1 && w < 20) begin
			idle(1);
			w++;
		end
		chk(16'(w), 16'(lat + 1), "first beat delay");
		for (int k = 0; k < n; k++) begin
			chk(16'(o_rdata_vld), 16'h0001, "beat valid");
			if (cmp) chk(o_rdata, e[k], "beat data");
			idle(1);
		end
		chk(16'(o_rdata_vld), 16'h0000, "burst end");
	endtask : rd
	////////////////////////////////////////////////////////////////
	task automatic t_init();
		int w;
		w = 0;
		while ((o_init_done !== 1'b1 || done2 !== 1'b1) && w < 200) begin
			idle(1);
			w++;
		end
		chk(16'(first_cyc >= HOLD), 16'h0001, "hold length");
		chk(16'(refs), 16'(N_REF), "init refreshes");
		chk(16'(dmode), 16'h0022, "init opcode");
		chk(16'(dloaded), 16'h0001, "mode loaded");
		chk(16'(dmode2), 16'h0022, "mode first opcode");
		chk(16'(dloaded2), 16'h0001, "mode first loaded");
		chk(16'(derr), 16'h0000, "order flag");
		chk(16'(dill), 16'h0000, "legal opcode");
		$display("test init done");
	endtask : t_init
	// burst write, sequential reads from two start columns, then an interleaved read
	task automatic t_burst();
		opn();
		wr(12'h008, DA);
		rd(12'h008, 4, 2, DA, 1'b1);
		rd(12'h009, 4, 2, '{DA[1], DA[2], DA[3], DA[0]}, 1'b1);
		load_mode_command(12'h03a);
		opn();
		rd(12'h009, 4, 3, '{DA[1], DA[0], DA[3], DA[2]}, 1'b1);
		$display("test burst done");
	endtask : t_burst
	// single-write mode stores beat zero only
	task automatic t_single();
		load_mode_command(12'h232);
		opn();
		wr(12'h008, '{16'hc3c3, 16'h0000, 16'h0000, 16'h0000});
		rd(12'h008, 4, 3, '{16'hc3c3, DA[1], DA[2], DA[3]}, 1'b1);
		$display("test single done");
	endtask : t_single
	// every length code, then the reserved codes
	task automatic t_len();
		for (int i = 0; i < 4; i++) begin
			load_mode_command(12'h020 | 12'(i));
			opn();
			rd(12'h008, 1 << i, 2, DA, 1'b0);
		end
		load_mode_command(12'h027);
		chk(16'(dill), 16'h0000, "page legal");
		foreach (RSV[i]) begin
			load_mode_command(RSV[i]);
			chk(16'(dill), 16'h0001, "reserved flagged");
		end
		load_mode_command(12'h022);
		chk(16'(dill), 16'h0000, "legal again");
		$display("test lengths done");
	endtask : t_len
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	////////////////////////////////////////////////////////////////
	initial begin
		i_rstn = 1'b0;
		i_mode = 12'h022;
		i_cmd_vld = 1'b0;
		i_cmd = 3'h0;
		i_addr = 12'h000;
		i_wdata = 16'h0000;
		i_wdata_vld = 1'b0;
		err_count = 0;
		total_checks = 0;
		repeat (6) @(posedge i_core_clk);
		#1;
		i_rstn = 1'b1;
		t_init();
		t_burst();
		t_single();
		t_len();
		tally_and_finish();
	end
	// tests need about 200 cycles; a hundred times that means a hang
	initial begin
		#200000;
		err_count++;
		$display("Error at %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule : tb
